// [bench/gvt_lock_tuner_tb.sv]
// self-checking bench of the oscillator bias lock tuner
`timescale 1ns/1ps
`default_nettype none
`include "gvt_consts.svh"

module gvt_lock_tuner_tb
  import gvt_pkg::*;
;
  localparam int unsigned SETTLE = 8;
  localparam int SH [5] = '{1, 16, 24, 32, 36};
  localparam logic [11:0] PE [6] = '{12'h0400, 12'h067f, 12'h0680, 12'h0b80, 12'h0b81, 12'h0fff};
  localparam logic [3:0]  BX [6] = '{4'h7, 4'h6, 4'h6, 4'h6, 4'h7, 4'h8};

  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b1;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'hf;
  logic [31:0] wb_dat = 32'h0000_0000;
  logic [31:0] wb_q, suc_word, rd;
  logic wb_ack, cal_go;
  gvt_tc_s tc = '0;
  gvt_tc_s tc_off, tc_on;
  logic tc_valid = 1'b0, spec_pwr = 1'b1, ovr_en = 1'b0;
  logic [2:0] pls = 3'h0;
  logic [3:0] lock_bias = 4'h1;
  logic [11:0] ovr_val = 12'h0000;
  logic [11:0] phase_err;
  logic [5:0] pll_lock, alarm;
  logic [15:0] rb;
  int n_mismatch = 0;
  int n_compared = 0;

  assign tc_off = '{`GVT_TC_APID, `GVT_TC_CAT, `GVT_TC_TYPE, `GVT_TC_SUBTYPE, 16'h0000};
  assign tc_on  = '{`GVT_TC_APID, `GVT_TC_CAT, `GVT_TC_TYPE, `GVT_TC_SUBTYPE, 16'h0001};

  always #25 clk_sys_i = ~clk_sys_i;

  gvt_lock_tuner #(.SETTLE_CYC(SETTLE), .CNT_W(16)) dut_u (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_q), .wb_ack_o(wb_ack),
    .tc_valid_i(tc_valid), .tc_i(tc),
    .table_init_done_i(pls[0]), .spec_powered_i(spec_pwr), .cal_request_i(pls[1]),
    .cal_go_o(cal_go), .phase_err_i(phase_err), .pll_lock_i(pll_lock),
    .lock_sample_i(pls[2]), .pll_alarm_o(alarm),
    .sensor_unit_control_word_o(suc_word), .bias_readback_register_o(rb));

  gvt_osc_model osc_u (
    .clk_sys_i(clk_sys_i), .ctrl_word_i(suc_word), .lock_bias_i(lock_bias),
    .ovr_en_i(ovr_en), .ovr_val_i(ovr_val), .phase_err_o(phase_err), .pll_lock_o(pll_lock));

  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  // no fixed latency assumed: wait for ack under a bound
  task automatic wb_xfer(input logic [7:0] a, input logic we, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= a;
    wb_dat <= d;
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    rd = wb_q;
    if (n >= 20)
      chk(32'h0000_0000, 32'h0000_0001);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask : wb_xfer

  // sequence, length and ack fields are stripped upstream
  task automatic send_tc(input gvt_tc_s t);
    @(posedge clk_sys_i);
    tc_valid <= 1'b1;
    tc       <= t;
    @(posedge clk_sys_i);
    tc_valid <= 1'b0;
  endtask : send_tc

  task automatic pulse(input int i);
    @(posedge clk_sys_i);
    pls[i] <= 1'b1;
    @(posedge clk_sys_i);
    pls[i] <= 1'b0;
  endtask : pulse

  task automatic wait_stat(input int idx);
    int n;
    n = 0;
    rd = 32'h0000_0000;
    while (rd[idx] !== 1'b1 && n < 200)
    begin
      wb_xfer(`GVT_ADR_STAT, 1'b0, 32'h0000_0000);
      n++;
    end
    chk(32'(rd[idx]), 32'h0000_0001);
  endtask : wait_stat

  task automatic check_bias(input logic [3:0] b);
    chk(suc_word, {12'h000, b, 16'h0000});
    chk({16'h0000, rb}, {16'h0000, b[0], b[1], b[2], b[3], 12'h000});
  endtask : check_bias

  task automatic check_reset();
    check_bias(4'h4);
    wb_xfer(`GVT_ADR_CTRL, 1'b0, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
  endtask : check_reset

  task automatic cal_check(input logic [11:0] pe, input logic [3:0] b);
    @(posedge clk_sys_i);
    ovr_val <= pe;
    repeat (2) @(posedge clk_sys_i);
    pulse(1);
    @(posedge clk_sys_i);
    chk(32'(cal_go), 32'h0000_0001);
    check_bias(b);
  endtask : cal_check

  // ==========================================================
  // tests
  initial
  begin
    repeat (2) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    check_reset();
    for (int i = 0; i < 5; i++)
      send_tc(tc_off ^ (43'h1 << SH[i]));
    wb_xfer(`GVT_ADR_CTRL, 1'b0, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    send_tc(tc_off);
    wb_xfer(`GVT_ADR_CTRL, 1'b0, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    check_bias(4'h4);
    send_tc(tc_on);
    wb_xfer(`GVT_ADR_CTRL, 1'b0, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    $display("test telecommand done");
    // target 1 forces the wrap from 15 to 0 on the way
    pulse(0);
    wait_stat(11);
    check_bias(4'h1);
    chk(32'(rd[12:5]), 32'h0000_004e);
    repeat (30) @(posedge clk_sys_i);
    check_bias(4'h1);
    wb_xfer(`GVT_ADR_BIAS, 1'b1, 32'h0000_0008);
    check_bias(4'h8);
    wb_xfer(8'h20, 1'b0, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    $display("test search done");
    ovr_en <= 1'b1;
    for (int i = 0; i < 6; i++)
      cal_check(PE[i], BX[i]);
    send_tc(tc_off);
    cal_check(12'h0400, 4'h8);
    send_tc(tc_on);
    spec_pwr <= 1'b0;
    cal_check(12'h0400, 4'h8);
    spec_pwr <= 1'b1;
    wb_xfer(`GVT_ADR_BIAS, 1'b1, 32'h0000_0000);
    cal_check(12'h0400, 4'h0);
    wb_xfer(`GVT_ADR_BIAS, 1'b1, 32'h0000_000f);
    cal_check(12'h0fff, 4'hf);
    $display("test correction done");
    pulse(2);
    repeat (2) @(posedge clk_sys_i);
    chk(32'(alarm), 32'h0000_003a);
    ovr_val <= 12'h0900;
    repeat (3) @(posedge clk_sys_i);
    pulse(2);
    chk(32'(alarm), 32'h0000_0000);
    wb_xfer(`GVT_ADR_LOCK, 1'b0, 32'h0000_0000);
    chk(rd, 32'h0000_0008);
    wb_xfer(`GVT_ADR_UNLK, 1'b0, 32'h0000_0000);
    chk(rd, 32'h0000_0004);
    $display("test lock count done");
    send_tc(tc_off);
    ovr_val <= 12'h0000;
    srst_i  <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    check_reset();
    pulse(0);
    wait_stat(12);
    check_bias(4'h4);
    chk(32'(rd[12:5]), 32'h0000_00a0);
    $display("test failed search done");
    finish_test();
  end

  initial
  begin
    #(50 * 20000);
    n_mismatch++;
    $display("[ERR] %0t run did not finish", $time);
    finish_test();
  end
endmodule : gvt_lock_tuner_tb
`default_nettype wire

// [bench/gvt_osc_model.sv]
// behavioural phase-lock loop of the oscillator, seen from the tuner
`timescale 1ns/1ps
`default_nettype none

module gvt_osc_model
(
  // clock
  input  wire logic        clk_sys_i,
  // oscillator control and bench steering
  input  wire logic [31:0] ctrl_word_i,
  input  wire logic [3:0]  lock_bias_i,
  input  wire logic        ovr_en_i,
  input  wire logic [11:0] ovr_val_i,
  // measurements
  output logic      [11:0] phase_err_o,
  output logic      [5:0]  pll_lock_o
);
  logic [3:0]  bias;
  logic [11:0] pe_d;

  assign bias = ctrl_word_i[19:16];

  // too high a bias pulls the error low, too low pushes it high
  always_comb
  begin
    if (ovr_en_i)
      pe_d = ovr_val_i;
    else if (bias == lock_bias_i)
      pe_d = 12'h0900;
    else if (bias > lock_bias_i)
      pe_d = 12'h0400;
    else
      pe_d = 12'h0d00;
  end

  // one cycle of lag, as a sampled converter would give
  always_ff @(posedge clk_sys_i)
  begin
    phase_err_o <= pe_d;
    pll_lock_o  <= (pe_d >= 12'h0680 && pe_d <= 12'h0b80) ? 6'h3f : 6'h05;
  end
endmodule : gvt_osc_model
`default_nettype wire

// [verilog/gvt_consts.svh]
// constants of the oscillator bias lock tuner
// How it works
// - accept command with process id 0x47, category 0xc, type 0xc0, subtype 0x15.
// - command data word 0 disables, 1 enables periodic correction.
// - enable flag is one after reset until a command or a control register write changes it.
// - a matching command updates the enable flag at once, nothing else.
// - bias setting loads 4 on every reset.
// - table-init done loads bias 3 and starts the lock search.
// - each search step adds one to bias, wrapping 15 to 0.
// - wait one second after each search step before sampling phase error.
// - phase error inside window keeps bias and ends search successfully.
// - after 32 failed iterations search stops with bias at 4.
// - after search bias holds except software write or periodic correction.
// - enabled and spectrometer powered, sample phase error before each calibration.
// - pre-calibration sample below 0x680 lowers bias by one.
// - pre-calibration sample above 0xb80 raises bias by one, then calibration proceeds.
// - periodic correction moves bias at most one count per calibration.
// - bias drives control word bits 19..16, lsb on bit 16.
// - readback register mirrors bias reversed: bit 0 at 15, bit 3 at 12.
// - alarm bits are set while the oscillator is out of lock.
// - count locked and unlocked lock-indicator findings separately and report both.
`ifndef GVT_CONSTS_SVH
`define GVT_CONSTS_SVH

// ==========================================================
// command identity
`define GVT_TC_APID      7'h47
`define GVT_TC_CAT       4'hc
`define GVT_TC_TYPE      8'hc0
`define GVT_TC_SUBTYPE   8'h15
`define GVT_TC_OFF       16'h0000
`define GVT_TC_ON        16'h0001

// ==========================================================
// bias and phase error
`define GVT_BIAS_RST     4'h4
`define GVT_SUC_RST      32'h0004_0000
`define GVT_RB_RST       16'h2000
`define GVT_BIAS_INIT    4'h3
`define GVT_BIAS_MIN     4'h0
`define GVT_BIAS_MAX     4'hf
`define GVT_PE_LO        12'h0680
`define GVT_PE_HI        12'h0b80
`define GVT_MAX_ITER     6'h20
`define GVT_LOCK_BITS    6

// ==========================================================
// timing: clock period and settle time in ns (1 s)
`define GVT_CLK_NS       32'h0000_0032
`define GVT_SETTLE_NS    32'h3b9a_ca00
`define GVT_SETTLE_CYC   (`GVT_SETTLE_NS / `GVT_CLK_NS)

// ==========================================================
// output field positions
`define GVT_SUC_LSB      16
`define GVT_RB_LSB       12

// ==========================================================
// register byte offsets
`define GVT_ADR_CTRL     8'h00
`define GVT_ADR_BIAS     8'h04
`define GVT_ADR_STAT     8'h08
`define GVT_ADR_LOCK     8'h0c
`define GVT_ADR_UNLK     8'h10
`define GVT_CTRL_EN      0

`endif

// [verilog/gvt_lock_tuner.sv]
// oscillator bias lock search, periodic correction and wishbone registers
`timescale 1ns/1ps
`default_nettype none
`include "gvt_consts.svh"

module gvt_lock_tuner
  import gvt_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = `GVT_SETTLE_CYC,
  parameter int unsigned CNT_W      = 16
)
(
  // clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              srst_i,
  // wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // telecommand path
  input  wire logic              tc_valid_i,
  input  wire gvt_tc_s           tc_i,
  // spectrometer and calibration sequencing
  input  wire logic              table_init_done_i,
  input  wire logic              spec_powered_i,
  input  wire logic              cal_request_i,
  output logic                   cal_go_o,
  // lock loop measurements
  input  wire logic [11:0]       phase_err_i,
  input  wire logic [5:0]        pll_lock_i,
  input  wire logic              lock_sample_i,
  output logic      [5:0]        pll_alarm_o,
  // oscillator control
  output logic      [31:0]       sensor_unit_control_word_o,
  output logic      [15:0]       bias_readback_register_o
);

  localparam int unsigned TW = $clog2(SETTLE_CYC + 1);
  localparam logic [TW-1:0] TMR_LAST = TW'(SETTLE_CYC - 1);

  // ==========================================================
  // bus decode
  logic wb_req;
  logic wb_wr;
  logic wr_ctrl;
  logic wr_bias;
  logic ack_q;

  assign wb_req  = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wb_wr   = wb_req & wb_we_i & wb_sel_i[0];
  assign wr_ctrl = wb_wr & (wb_adr_i == `GVT_ADR_CTRL);
  assign wr_bias = wb_wr & (wb_adr_i == `GVT_ADR_BIAS);

  // ==========================================================
  // command decode
  logic tc_hit;
  logic tc_known;

  assign tc_hit = tc_valid_i
                & (tc_i.apid == `GVT_TC_APID)
                & (tc_i.category == `GVT_TC_CAT)
                & (tc_i.ptype == `GVT_TC_TYPE)
                & (tc_i.subtype == `GVT_TC_SUBTYPE);
  // values other than 0 and 1 are dropped rather than guessed at
  assign tc_known = (tc_i.app_data == `GVT_TC_OFF) | (tc_i.app_data == `GVT_TC_ON);

  // ==========================================================
  // phase error window, unsigned and inclusive
  logic pe_low;
  logic pe_high;
  logic in_win;

  assign pe_low  = phase_err_i < `GVT_PE_LO;
  assign pe_high = phase_err_i > `GVT_PE_HI;
  assign in_win  = ~pe_low & ~pe_high;

  // ==========================================================
  // sequencer
  gvt_state_e    st_q;
  gvt_state_e    st_d;
  logic [3:0]    bias_q;
  logic [3:0]    bias_d;
  logic [5:0]    iter_q;
  logic [5:0]    iter_d;
  logic [TW-1:0] tmr_q;
  logic [TW-1:0] tmr_d;
  logic          en_q;
  logic          en_d;
  logic          found_q;
  logic          found_d;
  logic          fail_q;
  logic          fail_d;

  always_comb
  begin
    st_d    = st_q;
    bias_d  = bias_q;
    iter_d  = iter_q;
    tmr_d   = tmr_q;
    found_d = found_q;
    fail_d  = fail_q;
    en_d    = en_q;
    // command wins over a software write in the same cycle
    if (tc_hit && tc_known)
    begin
      en_d = tc_i.app_data[0];
    end
    else if (wr_ctrl)
    begin
      en_d = wb_dat_i[`GVT_CTRL_EN];
    end
    case (st_q)
      GVT_WAIT:
      begin
        if (table_init_done_i)
        begin
          bias_d = `GVT_BIAS_INIT;
          iter_d = '0;
          st_d   = GVT_STEP;
        end
      end
      GVT_STEP:
      begin
        bias_d = bias_q + 4'h1;
        iter_d = iter_q + 6'h01;
        tmr_d  = '0;
        st_d   = GVT_SETTLE;
      end
      GVT_SETTLE:
      begin
        if (tmr_q == TMR_LAST)
        begin
          st_d = GVT_SAMPLE;
        end
        else
        begin
          tmr_d = tmr_q + TW'(1);
        end
      end
      GVT_SAMPLE:
      begin
        if (in_win)
        begin
          found_d = 1'b1;
          st_d    = GVT_RUN;
        end
        else if (iter_q >= `GVT_MAX_ITER)
        begin
          bias_d = `GVT_BIAS_RST;
          fail_d = 1'b1;
          st_d   = GVT_RUN;
        end
        else
        begin
          st_d = GVT_STEP;
        end
      end
      GVT_RUN:
      begin
        // one step at most per calibration; the ends saturate
        if (cal_request_i)
        begin
          if (en_q && spec_powered_i)
          begin
            if (pe_low && bias_q != `GVT_BIAS_MIN)
            begin
              bias_d = bias_q - 4'h1;
            end
            else if (pe_high && bias_q != `GVT_BIAS_MAX)
            begin
              bias_d = bias_q + 4'h1;
            end
          end
        end
        else if (wr_bias)
        begin
          bias_d = wb_dat_i[3:0];
        end
      end
      default:
      begin
        st_d = GVT_WAIT;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      st_q    <= GVT_WAIT;
      bias_q  <= `GVT_BIAS_RST;
      iter_q  <= '0;
      tmr_q   <= '0;
      en_q    <= 1'b1;
      found_q <= 1'b0;
      fail_q  <= 1'b0;
    end
    else
    begin
      st_q    <= st_d;
      bias_q  <= bias_d;
      iter_q  <= iter_d;
      tmr_q   <= tmr_d;
      en_q    <= en_d;
      found_q <= found_d;
      fail_q  <= fail_d;
    end
  end

  // ==========================================================
  // pin images of the bias, alarms and calibration release
  logic [31:0]    suc_d;
  logic [15:0]    rb_d;
  logic [CNT_W-1:0] pop;
  logic [CNT_W-1:0] lk_q;
  logic [CNT_W-1:0] lk_d;
  logic [CNT_W-1:0] ul_q;
  logic [CNT_W-1:0] ul_d;

  always_comb
  begin
    suc_d = '0;
    rb_d  = '0;
    pop   = '0;
    suc_d[`GVT_SUC_LSB +: 4] = bias_d;
    for (int i = 0; i < 4; i++)
    begin
      rb_d[`GVT_RB_LSB + 3 - i] = bias_d[i];
    end
    for (int i = 0; i < `GVT_LOCK_BITS; i++)
    begin
      pop = pop + CNT_W'(pll_lock_i[i]);
    end
    lk_d = lk_q;
    ul_d = ul_q;
    if (lock_sample_i)
    begin
      lk_d = lk_q + pop;
      ul_d = ul_q + (CNT_W'(`GVT_LOCK_BITS) - pop);
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      sensor_unit_control_word_o <= `GVT_SUC_RST;
      bias_readback_register_o   <= `GVT_RB_RST;
      pll_alarm_o                <= '0;
      cal_go_o                   <= 1'b0;
      lk_q                       <= '0;
      ul_q                       <= '0;
    end
    else
    begin
      sensor_unit_control_word_o <= suc_d;
      bias_readback_register_o   <= rb_d;
      pll_alarm_o                <= ~pll_lock_i;
      cal_go_o                   <= cal_request_i;
      lk_q                       <= lk_d;
      ul_q                       <= ul_d;
    end
  end

  // ==========================================================
  // register read and acknowledge
  logic [31:0] rd_d;
  logic        ack_d;

  always_comb
  begin
    ack_d = wb_req;
    rd_d  = '0;
    if (wb_adr_i == `GVT_ADR_CTRL)
    begin
      rd_d[`GVT_CTRL_EN] = en_q;
    end
    else if (wb_adr_i == `GVT_ADR_BIAS)
    begin
      rd_d[3:0] = bias_q;
    end
    else if (wb_adr_i == `GVT_ADR_STAT)
    begin
      rd_d[15:0] = {st_q, fail_q, found_q, iter_q, 1'b0, 1'b0, en_q, 2'b00};
    end
    else if (wb_adr_i == `GVT_ADR_LOCK)
    begin
      rd_d[CNT_W-1:0] = lk_q;
    end
    else if (wb_adr_i == `GVT_ADR_UNLK)
    begin
      rd_d[CNT_W-1:0] = ul_q;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      ack_q    <= 1'b0;
      wb_dat_o <= '0;
    end
    else
    begin
      ack_q    <= ack_d;
      wb_dat_o <= ack_d ? rd_d : 32'h0000_0000;
    end
  end

  assign wb_ack_o = ack_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  chk_tc_enable: assert property (
    tc_hit && tc_i.app_data == `GVT_TC_ON |=> en_q)
    else $error("enable command not applied");
  chk_tc_disable: assert property (
    tc_hit && tc_i.app_data == `GVT_TC_OFF |=> !en_q)
    else $error("disable command not applied");
  chk_reset_values: assert property (@(posedge clk_sys_i) disable iff (1'b0)
    srst_i |=> bias_q == `GVT_BIAS_RST && en_q)
    else $error("reset values wrong");
  chk_init_load: assert property (
    st_q == GVT_WAIT && table_init_done_i |=> bias_q == `GVT_BIAS_INIT && st_q == GVT_STEP)
    else $error("init load wrong");
  chk_step_wrap: assert property (
    st_q == GVT_STEP |=> bias_q == 4'($past(bias_q) + 4'h1) && st_q == GVT_SETTLE)
    else $error("search step wrong");
  chk_settle_time: assert property (
    st_q == GVT_SETTLE ##1 st_q == GVT_SAMPLE |-> $past(tmr_q) == TMR_LAST)
    else $error("settle time wrong");
  chk_window_keep: assert property (
    st_q == GVT_SAMPLE && in_win |=> st_q == GVT_RUN && $stable(bias_q) && found_q)
    else $error("lock not kept");
  chk_give_up: assert property (
    st_q == GVT_SAMPLE && !in_win && iter_q == `GVT_MAX_ITER |=> bias_q == `GVT_BIAS_RST && fail_q)
    else $error("search abandon wrong");
  chk_hold_run: assert property (
    st_q == GVT_RUN && !cal_request_i && !wr_bias |=> $stable(bias_q))
    else $error("bias moved unasked");
  chk_cal_low: assert property (
    st_q == GVT_RUN && cal_request_i && en_q && spec_powered_i && pe_low && bias_q != 4'h0
    |=> bias_q == 4'($past(bias_q) - 4'h1) && cal_go_o)
    else $error("low correction wrong");
  chk_cal_high: assert property (
    st_q == GVT_RUN && cal_request_i && en_q && spec_powered_i && pe_high && bias_q != 4'hf
    |=> bias_q == 4'($past(bias_q) + 4'h1) && cal_go_o)
    else $error("high correction wrong");
  chk_pin_map: assert property (
    sensor_unit_control_word_o[19:16] == bias_q
    && bias_readback_register_o[15] == bias_q[0] && bias_readback_register_o[12] == bias_q[3])
    else $error("bias pin map wrong");
  chk_alarm_count: assert property (
    lock_sample_i |=> pll_alarm_o == ~$past(pll_lock_i) && lk_q == $past(lk_q) + $past(pop))
    else $error("alarm or count wrong");

  cov_found: cover property (st_q == GVT_SAMPLE && in_win);
  cov_fail: cover property (st_q == GVT_SAMPLE && !in_win && iter_q == `GVT_MAX_ITER);
  cov_adjust: cover property (st_q == GVT_RUN && cal_request_i && en_q && spec_powered_i && pe_low);

endmodule : gvt_lock_tuner
`default_nettype wire

// [verilog/gvt_pkg.sv]
// types of the oscillator bias lock tuner
package gvt_pkg;

  // ==========================================================
  // search sequencer, gray along wait, step, settle, sample, run
  typedef enum logic [2:0] {
    GVT_WAIT   = 3'h0,
    GVT_STEP   = 3'h1,
    GVT_SETTLE = 3'h3,
    GVT_SAMPLE = 3'h2,
    GVT_RUN    = 3'h6
  } gvt_state_e;

  // ==========================================================
  // decoded telecommand fields
  typedef struct packed {
    logic [6:0]  apid;
    logic [3:0]  category;
    logic [7:0]  ptype;
    logic [7:0]  subtype;
    logic [15:0] app_data;
  } gvt_tc_s;

endpackage : gvt_pkg
